// ---- verilog/pulse_and_step_output.sv ----
// Two fast outputs: plain, PWM, counter match or stepper, APB registers
//
// Functional notes
// - Two outputs, each one of four modes
// - Plain mode follows the drive bit
// - Independent PWM channels, live parameter changes
// - Duty word 0..32000 sets high fraction
// - Duty 0 always low, 32000 always high
// - Frequency word in hertz sets period
// - PWM low until both words non-zero
// - Stop mode: hold or stop parameters
// - Zero stop frequency or duty: low
// - Match event turns on, off or toggles
// - Five stepper words captured at start
// - Start and run frequencies bound the ramps
// - Ramp requires start 1..run frequency
// - Run frequency must be 1..5000
// - Accel ramps linearly, zero count skips
// - Accel or decel count of one errors
// - Run phase constant, zero skips
// - Decel ramps linearly down, zero skips
// - Ready high only while stepper idle
// - Error on bad words or abort by start release, not stop
// - Start held to the end, else abort
// - Stop mode drops stepper output immediately
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module pulse_and_step_output (
  input  wire logic                      pclk,            // 250 MHz clock
  input  wire logic                      presetn,         // Async reset, low
  input  wire logic                      psel,            // APB select
  input  wire logic                      penable,         // APB enable
  input  wire logic                      pwrite,          // APB direction
  input  wire logic [hso_pkg::ADDR_W-1:0] paddr,          // APB byte address
  input  wire logic [31:0]               pwdata,          // APB write data
  output logic      [31:0]               prdata,          // APB read data
  output logic                           pready,          // APB ready
  output logic                           pslverr,         // APB error
  input  wire logic                      ctrl_stop,       // Controller stopped
  input  wire logic                      download_active, // Program loading
  input  wire logic [1:0]                match_hit,       // Counter match
  output logic                           fast_output_one, // Output 1
  output logic                           fast_output_two  // Output 2
);
  import hso_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Address check: aligned word of channel 0 or 1, index up to status
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[ADDR_W-1:7] == '0) && (a[1:0] == 2'b00)
              && (a[5:2] <= IDX_STATUS);
  endfunction

  // PWM level for a phase within one period of CLK_HZ units
  function automatic logic pwm_level(input logic [31:0] ph,
                                     input logic [31:0] duty);
    logic [47:0] thr;
    thr = {16'h0000, duty} * {32'h0000_0000, DUTY_SCALE};
    if (duty == 32'h0000_0000)
      pwm_level = 1'b0;
    else if (duty >= DUTY_FULL)
      pwm_level = 1'b1;
    else
      pwm_level = {15'h0000, ph, 1'b0} < thr;
  endfunction

  // First non-empty phase at or after the given one
  function automatic step_phase_t next_phase(input logic [1:0]  from,
                                             input logic [31:0] ac,
                                             input logic [31:0] rc,
                                             input logic [31:0] dc);
    if (from == 2'd0 && ac != 32'h0000_0000)
      next_phase = PH_ACCEL;
    else if (from <= 2'd1 && rc != 32'h0000_0000)
      next_phase = PH_RUN;
    else if (from <= 2'd2 && dc != 32'h0000_0000)
      next_phase = PH_DECEL;
    else
      next_phase = PH_NONE;
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  logic [31:0]       param_reg [2][NUM_PARAMS];
  logic [CTRL_W-1:0] ctrl_reg  [2];
  logic [2:0]        stat_vec  [2];
  logic [1:0]        out_vec;
  logic              acc_ch;
  logic [3:0]        acc_idx;
  logic              wr_en;

  assign acc_ch  = paddr[6];
  assign acc_idx = paddr[5:2];
  assign wr_en   = psel & penable & pready & pwrite & addr_ok(paddr);

  // Ready one cycle after setup, so every transfer has no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok(paddr);
      if (psel && !penable && !pwrite && addr_ok(paddr)) begin
        if (acc_idx == IDX_STATUS)
          prdata <= {29'h0000_0000, stat_vec[acc_ch]};
        else if (acc_idx == IDX_CTRL)
          prdata <= {25'h000_0000, ctrl_reg[acc_ch]};
        else
          prdata <= param_reg[acc_ch][acc_idx[2:0]];
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // Parameter words, writable at any time, also while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < 2; c++) begin
        for (int w = 0; w < NUM_PARAMS; w++) begin
          param_reg[c][w] <= 32'h0000_0000;
        end
      end
    end else if (wr_en && acc_idx < IDX_CTRL) begin
      param_reg[acc_ch][acc_idx[2:0]] <= pwdata;
    end
  end

  // Control words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg[0] <= CTRL_RESET;
      ctrl_reg[1] <= CTRL_RESET;
    end else if (wr_en && acc_idx == IDX_CTRL) begin
      ctrl_reg[acc_ch] <= pwdata[CTRL_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Output channels, identical and independent
  // ----------------------------------------------------------------------
  div_if div_bus [2] ();

  for (genvar c = 0; c < 2; c++) begin : g_chan
    mode_t       mode;
    match_act_t  act;
    logic        start_bit;
    logic        hold_bit;
    logic [31:0] run_freq;
    logic [31:0] run_duty;
    logic [31:0] stop_freq;
    logic [31:0] stop_duty;
    logic [31:0] phase_step;
    logic [32:0] phase_sum;
    logic [31:0] pwm_phase_reg;
    logic        armed_reg;
    logic        pwm_out_reg;
    logic        match_out_reg;
    logic        out_reg;

    assign mode      = mode_t'(ctrl_reg[c][CTRL_MODE_LO +: 2]);
    assign act       = match_act_t'(ctrl_reg[c][CTRL_ACT_LO +: 2]);
    assign start_bit = ctrl_reg[c][CTRL_START];
    assign hold_bit  = ctrl_reg[c][CTRL_HOLD];
    assign run_duty  = param_reg[c][IDX_DUTY[2:0]];
    assign run_freq  = param_reg[c][IDX_FREQ[2:0]];
    assign stop_freq = param_reg[c][IDX_SFREQ[2:0]];
    assign stop_duty = param_reg[c][IDX_SDUTY[2:0]];

    // PWM phase accumulator; frequencies at or above clock are clamped
    assign phase_step = ctrl_stop ? stop_freq : run_freq;
    assign phase_sum  = {1'b0, pwm_phase_reg}
                        + {1'b0, (phase_step >= CLK_HZ) ? CLK_HZ - 32'h1
                                                        : phase_step};
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        pwm_phase_reg <= 32'h0000_0000;
      else if (phase_sum >= {1'b0, CLK_HZ})
        pwm_phase_reg <= 32'(phase_sum - {1'b0, CLK_HZ});
      else
        pwm_phase_reg <= phase_sum[31:0];
    end

    // Armed once both run words are non-zero; a download disarms
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        armed_reg <= 1'b0;
      else if (download_active)
        armed_reg <= 1'b0;
      else if (run_freq != 32'h0000_0000 && run_duty != 32'h0000_0000)
        armed_reg <= 1'b1;
    end

    // PWM level, with stop-mode behaviour
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        pwm_out_reg <= 1'b0;
      else if (ctrl_stop && hold_bit)
        pwm_out_reg <= pwm_out_reg;
      else if (ctrl_stop)
        pwm_out_reg <= (stop_freq != 32'h0000_0000)
                       && pwm_level(pwm_phase_reg, stop_duty);
      else
        pwm_out_reg <= armed_reg
                       && pwm_level(pwm_phase_reg, run_duty);
    end

    // Counter match action
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        match_out_reg <= 1'b0;
      else if (match_hit[c]) begin
        case (act)
          ACT_ON:     match_out_reg <= 1'b1;
          ACT_OFF:    match_out_reg <= 1'b0;
          ACT_TOGGLE: match_out_reg <= ~match_out_reg;
          default:    match_out_reg <= match_out_reg;
        endcase
      end
    end

    // --------------------------------------------------------------------
    // Stepper sequencer
    // --------------------------------------------------------------------
    step_state_t state_reg;
    step_phase_t phase_reg;
    step_phase_t enter_ph;
    logic        start_d_reg;
    logic        error_reg;
    logic        down_reg;
    logic        slope_reg;
    logic [31:0] lat_reg [5];
    logic [31:0] cnt_reg;
    logic [31:0] freq_reg;
    logic [31:0] den_reg;
    logic [32:0] err_acc_reg;
    logic [31:0] step_acc_reg;
    logic [32:0] step_sum;
    logic [32:0] err_sum;
    logic [31:0] src [5];
    logic        start_rise;
    logic        bad_words;
    logic        step_end;
    logic        abort;
    logic        enter;

    // Fresh words at start, captured copies at later phase changes
    for (genvar w = 0; w < 5; w++) begin : g_src
      assign src[w] = (state_reg == ST_IDLE) ? param_reg[c][w]
                                             : lat_reg[w];
    end

    assign start_rise = start_bit & ~start_d_reg & (mode == MODE_STEP);
    assign bad_words  =
      (src[1] == 32'h0000_0000) || (src[1] > STEP_MAX_HZ)
      || ((src[2] != 32'h0000_0000 || src[4] != 32'h0000_0000)
          && (src[0] == 32'h0000_0000 || src[0] > src[1]))
      || (src[2] == 32'h0000_0001) || (src[4] == 32'h0000_0001);
    assign step_sum   = {1'b0, step_acc_reg} + {1'b0, freq_reg};
    assign step_end   = (state_reg == ST_RUN) && (step_sum >= {1'b0, CLK_HZ});
    assign abort      = (state_reg != ST_IDLE) && (ctrl_stop || !start_bit);
    assign err_sum    = err_acc_reg + {1'b0, div_bus[c].remainder};

    // Phase entry, at start or after the last cycle of a phase
    always_comb begin
      enter    = 1'b0;
      enter_ph = PH_NONE;
      if (state_reg == ST_IDLE) begin
        enter    = start_rise && !ctrl_stop && !bad_words;
        enter_ph = next_phase(2'd0, src[2], src[3], src[4]);
      end else if (step_end && cnt_reg == 32'h0000_0001 && !abort) begin
        enter    = 1'b1;
        enter_ph = next_phase(2'(phase_reg + 2'd1),
                              src[2], src[3], src[4]);
      end
    end

    // Ramps need the slope (run - start) / (count - 1)
    assign div_bus[c].start    = enter && (enter_ph == PH_ACCEL
                                           || enter_ph == PH_DECEL);
    assign div_bus[c].dividend = src[1] - src[0];
    assign div_bus[c].divisor  = ((enter_ph == PH_ACCEL) ? src[2]
                                                          : src[4])
                                 - 32'h0000_0001;

    step_divider u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (div_bus[c])
    );

    // Start edge tracker and error flag
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        start_d_reg <= 1'b0;
        error_reg   <= 1'b0;
      end else begin
        start_d_reg <= start_bit;
        if (abort && !ctrl_stop)
          error_reg <= 1'b1;
        else if (state_reg == ST_IDLE && start_rise && !ctrl_stop)
          error_reg <= bad_words;
      end
    end

    // Sequencer state, counts and the stepped frequency
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_reg    <= ST_IDLE;
        phase_reg    <= PH_NONE;
        cnt_reg      <= 32'h0000_0000;
        freq_reg     <= 32'h0000_0000;
        den_reg      <= 32'h0000_0000;
        err_acc_reg  <= 33'h0_0000_0000;
        step_acc_reg <= 32'h0000_0000;
        down_reg     <= 1'b0;
        slope_reg    <= 1'b0;
        for (int w = 0; w < 5; w++) lat_reg[w] <= 32'h0000_0000;
      end else if (abort) begin
        state_reg    <= ST_IDLE;
        step_acc_reg <= 32'h0000_0000;
        cnt_reg      <= 32'h0000_0000;
      end else if (enter) begin
        if (state_reg == ST_IDLE) begin
          for (int w = 0; w < 5; w++) lat_reg[w] <= src[w];
        end
        phase_reg    <= enter_ph;
        step_acc_reg <= 32'h0000_0000;
        err_acc_reg  <= 33'h0_0000_0000;
        down_reg     <= (enter_ph == PH_DECEL);
        slope_reg    <= (enter_ph != PH_RUN);
        den_reg      <= div_bus[c].divisor;
        case (enter_ph)
          PH_ACCEL: begin
            cnt_reg   <= src[2];
            freq_reg  <= src[0];
            state_reg <= ST_DIV;
          end
          PH_RUN: begin
            cnt_reg   <= src[3];
            freq_reg  <= src[1];
            state_reg <= ST_RUN;
          end
          PH_DECEL: begin
            cnt_reg   <= src[4];
            freq_reg  <= src[1];
            state_reg <= ST_DIV;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end else if (state_reg == ST_DIV) begin
        if (div_bus[c].done) state_reg <= ST_RUN;
      end else if (step_end) begin
        // One whole period of the accumulator is one output cycle
        step_acc_reg <= 32'h0000_0000;
        cnt_reg      <= cnt_reg - 32'h0000_0001;
        if (cnt_reg == 32'h0000_0001)
          state_reg <= ST_IDLE;
        // Exact linear ramp: whole slope plus carried remainder
        if (slope_reg) begin
          if (err_sum >= {1'b0, den_reg}) begin
            err_acc_reg <= err_sum - {1'b0, den_reg};
            freq_reg    <= down_reg
              ? freq_reg - div_bus[c].quotient - 32'h0000_0001
              : freq_reg + div_bus[c].quotient + 32'h0000_0001;
          end else begin
            err_acc_reg <= err_sum;
            freq_reg    <= down_reg ? freq_reg - div_bus[c].quotient
                                    : freq_reg + div_bus[c].quotient;
          end
        end
      end else if (state_reg == ST_RUN) begin
        step_acc_reg <= step_sum[31:0];
      end
    end

    // Output select per mode, stepper forced low in stop mode
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
        out_reg <= 1'b0;
      else begin
        case (mode)
          MODE_PLAIN: out_reg <= ctrl_reg[c][CTRL_DRIVE];
          MODE_PWM:   out_reg <= pwm_out_reg;
          MODE_MATCH: out_reg <= match_out_reg;
          MODE_STEP:  out_reg <= !abort && state_reg == ST_RUN
                                 && step_acc_reg < CLK_HALF;
          default:    out_reg <= 1'b0;
        endcase
      end
    end

    assign out_vec[c]  = out_reg;
    assign stat_vec[c] = {out_reg, error_reg,
                          state_reg == ST_IDLE};
  end

  // Pins come straight from the per-channel output flops
  assign fast_output_one = out_vec[0];
  assign fast_output_two = out_vec[1];

endmodule // pulse_and_step_output

// ---- shared/hso_pkg.sv ----
// Constants and types shared by the pulse and step output block
package hso_pkg;

  // ----------------------------------------------------------------------
  // Clock and scaling
  // ----------------------------------------------------------------------
  localparam logic [31:0] CLK_HZ      = 32'h0EE6_B280; // 250 MHz in hertz
  localparam logic [31:0] CLK_HALF    = 32'h0773_5940; // Half a step period
  localparam logic [31:0] DUTY_FULL   = 32'h0000_7D00; // 32000, always on
  localparam logic [15:0] DUTY_SCALE  = 16'h3D09;      // 2*CLK_HZ/32000
  localparam logic [31:0] STEP_MAX_HZ = 32'h0000_1388; // 5000 Hz ceiling

  // ----------------------------------------------------------------------
  // Register map: channel c at byte offset c*0x40
  // ----------------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam int          NUM_PARAMS  = 7;
  localparam logic [3:0]  IDX_DUTY    = 4'h0; // duty / step start freq
  localparam logic [3:0]  IDX_FREQ    = 4'h1; // freq / step run freq
  localparam logic [3:0]  IDX_ACCEL   = 4'h2; // step accel count
  localparam logic [3:0]  IDX_RUNCNT  = 4'h3; // step run count
  localparam logic [3:0]  IDX_DECEL   = 4'h4; // step decel count
  localparam logic [3:0]  IDX_SFREQ   = 4'h5; // stop-mode frequency
  localparam logic [3:0]  IDX_SDUTY   = 4'h6; // stop-mode duty
  localparam logic [3:0]  IDX_CTRL    = 4'h7; // control bits
  localparam logic [3:0]  IDX_STATUS  = 4'h8; // status bits, read only

  // Control register fields
  localparam int          CTRL_MODE_LO = 0; // [1:0] output mode
  localparam int          CTRL_DRIVE   = 2; // plain output drive bit
  localparam int          CTRL_START   = 3; // stepper start, held
  localparam int          CTRL_ACT_LO  = 4; // [5:4] match action
  localparam int          CTRL_HOLD    = 6; // hold last state on stop
  localparam int          CTRL_W       = 7;
  localparam logic [6:0]  CTRL_RESET   = 7'h00;

  // Status register fields
  localparam int          STAT_READY  = 0;
  localparam int          STAT_ERROR  = 1;
  localparam int          STAT_LEVEL  = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'b00,
    MODE_PWM   = 2'b01,
    MODE_MATCH = 2'b10,
    MODE_STEP  = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_ON     = 2'b01,
    ACT_OFF    = 2'b10,
    ACT_TOGGLE = 2'b11
  } match_act_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01,
    ST_RUN  = 2'b10
  } step_state_t;

  typedef enum logic [1:0] {
    PH_ACCEL = 2'b00,
    PH_RUN   = 2'b01,
    PH_DECEL = 2'b10,
    PH_NONE  = 2'b11
  } step_phase_t;

endpackage

// ---- shared/div_if.sv ----
// Request and answer signals of the slope divider
`timescale 1ns/100ps
interface div_if;
  logic        start;     // One-cycle request
  logic [31:0] dividend;  // Frequency span
  logic [31:0] divisor;   // Cycle count minus one
  logic [31:0] quotient;  // Whole slope step
  logic [31:0] remainder; // Fractional slope part
  logic        done;      // One-cycle answer

  modport requester (output start, dividend, divisor,
                     input  quotient, remainder, done);
  modport server    (input  start, dividend, divisor,
                     output quotient, remainder, done);
endinterface

// ---- verilog/step_divider.sv ----
// Sequential restoring divider for the stepper ramp slope
`timescale 1ns/100ps
module step_divider (
  input wire logic pclk,    // System clock
  input wire logic presetn, // Async reset, active low
  div_if.server    bus      // Divide request and answer
);
  import hso_pkg::*;

  logic [31:0] quot_reg;
  logic [31:0] rem_reg;
  logic [31:0] den_reg;
  logic [5:0]  bits_reg;
  logic        busy_reg;
  logic        done_reg;
  logic [33:0] trial;

  // Trial subtraction, one quotient bit per clock
  assign trial = {1'b0, rem_reg, quot_reg[31]} - {2'b00, den_reg};

  // ----------------------------------------------------------------------
  // Iteration: 33 clocks from start to done
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quot_reg <= 32'h0000_0000;
      rem_reg  <= 32'h0000_0000;
      den_reg  <= 32'h0000_0000;
      bits_reg <= 6'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (bus.start) begin
        quot_reg <= bus.dividend;
        rem_reg  <= 32'h0000_0000;
        den_reg  <= bus.divisor;
        bits_reg <= 6'h20;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (!trial[33]) begin
          rem_reg  <= trial[31:0];
          quot_reg <= {quot_reg[30:0], 1'b1};
        end else begin
          rem_reg  <= {rem_reg[30:0], quot_reg[31]};
          quot_reg <= {quot_reg[30:0], 1'b0};
        end
        bits_reg <= bits_reg - 6'h01;
        if (bits_reg == 6'h01) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign bus.quotient  = quot_reg;
  assign bus.remainder = rem_reg;
  assign bus.done      = done_reg;

endmodule // step_divider

// ---- test/pso_load.sv ----
// Load model that counts rising edges on both fast outputs
`timescale 1ns/100ps
module pso_load (
  input  wire logic        pclk,  // Clock
  input  wire logic        clr,   // Restart count
  input  wire logic        out_a, // Output 1
  input  wire logic        out_b, // Output 2
  output logic      [31:0] rises  // Edges seen
);
  logic [1:0] last_reg; // Previous levels
  // A driver steps once per rising edge, so only edges count
  always @(posedge pclk) begin
    last_reg <= {out_b, out_a};
    rises <= clr ? 32'h0000_0000 : rises + 32'(out_a & ~last_reg[0])
             + 32'(out_b & ~last_reg[1]);
  end
endmodule // pso_load

// ---- test/pso_chk.sv ----
// Port assertions for the pulse and step output block
`timescale 1ns/100ps
module pso_chk (
  input wire logic                       pclk,           // Clock
  input wire logic                       presetn,        // Reset
  input wire logic                       psel,           // Select
  input wire logic                       penable,        // Enable
  input wire logic                       pwrite,         // Write
  input wire logic [hso_pkg::ADDR_W-1:0] paddr,          // Address
  input wire logic [31:0]                pwdata,         // Wdata
  input wire logic [31:0]                prdata,         // Rdata
  input wire logic                       pready,         // Ready
  input wire logic [1:0]                 match_hit,      // Match
  input wire logic                       pslverr,        // Error
  input wire logic                       ctrl_stop,      // Stop
  input wire logic                       fast_output_one // Out 1
);
  import hso_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [6:0] ctl_reg; // Channel 0 control shadow
  sequence s_setup; psel && !penable; endsequence
  sequence s_taken; psel && penable && pready; endsequence
  // Mode is not on a port, so follow control writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctl_reg <= CTRL_RESET;
    else if (psel && penable && pready && pwrite && paddr == 12'h01C)
      ctl_reg <= pwdata[6:0];
  end
  a_setup_ready: assert property (s_setup |=> pready) else $error("ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("held");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("idle data");
  a_bad_addr: assert property ((s_setup and paddr[11:7] != 5'h00) |=> pslverr)
    else $error("unmapped");
  a_plain_follow: assert property (
    s_taken ##0 (pwrite && paddr == 12'h01C && pwdata[1:0] == MODE_PLAIN)
    |-> ##2 fast_output_one == $past(pwdata[CTRL_DRIVE], 2)) else $error("pl");
  a_match_toggle: assert property (
    ctl_reg[1:0] == MODE_MATCH && ctl_reg[5:4] == ACT_TOGGLE && match_hit[0]
    |-> ##[1:3] $changed(fast_output_one)) else $error("match");
  a_stop_drop: assert property (
    $rose(ctrl_stop) && ctl_reg[1:0] == MODE_STEP |-> ##[1:2] !fast_output_one)
    else $error("stop");
  a_err_idle: assert property (
    s_taken ##0 (!pwrite && paddr == 12'h020)
    |-> prdata[STAT_READY] || !prdata[STAT_ERROR]) else $error("busy err");
endmodule // pso_chk

// ---- test/testbench.sv ----
// Self-checking bench for the pulse and step output block
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module testbench;
  import hso_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, clr = 1;
  logic ctrl_stop = 0, download_active = 0, pready, pslverr, o1, o2;
  logic err, bad, busy;
  logic [1:0] match_hit = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, rises, hi, w[5];
  int errors = 0, compares = 0;
  pulse_and_step_output dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl_stop,
    .download_active, .match_hit, .fast_output_one(o1),
    .fast_output_two(o2));
  pso_load load_u (.pclk, .clr, .out_a(o1), .out_b(o2), .rises);
  always #2 pclk = ~pclk;
  function automatic logic exp_err(input logic [31:0] s, r, a, d);
    return r == 0 || r > STEP_MAX_HZ || a == 1 || d == 1 ||
      ((a != 0 || d != 0) && (s == 0 || s > r));
  endfunction
  task automatic conclude;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One APB transfer, ready awaited under a bound
  task automatic apb(input logic wr, input logic [11:0] ad,
                     input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 9);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  initial begin
    hi = $urandom(32'h856A);
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h020, 0);
    `CHK(rd, 32'h0000_0001)
    for (int i = 0; i < 14; i++) begin
      hi = $urandom;
      apb(1, 12'(i / 7 * 64 + i % 7 * 4), hi);
      apb(0, 12'(i / 7 * 64 + i % 7 * 4), 0);
      `CHK(rd, hi)
    end
    apb(0, 12'h080, 0);
    `CHK({err, rd}, 33'h1_0000_0000)
    for (int c = 0; c < 2; c++) begin
      apb(1, 12'(c * 64 + 28), 32'h0000_0004);
      repeat (2) @(posedge pclk);
      `CHK(c ? o2 : o1, 1'b1)
    end
    // Download clears arming, so full duty waits for a frequency
    apb(1, 12'h004, 0);
    download_active <= 1;
    @(posedge pclk);
    download_active <= 0;
    apb(1, 12'h000, DUTY_FULL);
    apb(1, 12'h01C, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    `CHK(o1, 1'b0)
    apb(1, 12'h004, $urandom | 1);
    repeat (4) @(posedge pclk);
    `CHK(o1, 1'b1)
    apb(1, 12'h004, 32'h000F_4240);
    apb(1, 12'h000, 32'h0000_3E80);
    repeat (4) @(posedge pclk);
    clr <= 1;
    @(posedge pclk);
    clr <= 0;
    hi = 0;
    repeat (1000) @(posedge pclk) hi += 32'(o1);
    @(negedge pclk);
    `CHK(hi, 32'(1000 * 16000 / 32000))
    `CHK(rises, 32'(1000 * 32'h000F_4240 / CLK_HZ))
    apb(1, 12'h018, 0);
    ctrl_stop <= 1;
    repeat (4) @(posedge pclk);
    hi = 0;
    repeat (250) @(posedge pclk) hi += 32'(o1);
    `CHK(hi, 32'h0000_0000)
    ctrl_stop <= 0;
    for (int k = 1; k < 4; k++) begin
      apb(1, 12'h01C, 32'(k * 16 + 2));
      repeat (2) @(posedge pclk);
      bad = o1;
      match_hit <= 2'b01;
      @(posedge pclk);
      match_hit <= 2'b00;
      repeat (3) @(posedge pclk);
      `CHK(o1, k == 1 ? 1'b1 : k == 2 ? 1'b0 : ~bad)
    end
    for (int i = 0; i < 25; i++) begin
      w = '{$urandom % 3 * 60, i % 4 < 2 ? 100 * (i % 4) : 4998 + i % 4,
            $urandom % 3, $urandom % 2 * 3, $urandom % 3};
      if (i == 23) w = '{0, 5000, 0, 0, 0};
      if (i == 24) w = '{60, 100, 2, 3, 2};
      foreach (w[j]) apb(1, 12'(j * 4), w[j]);
      bad = exp_err(w[0], w[1], w[2], w[4]);
      busy = !bad && (w[2] | w[3] | w[4]) != 0;
      apb(1, 12'h01C, 32'h0000_000B);
      repeat (2) @(posedge pclk);
      if (i == 24) begin
        repeat (40) @(posedge pclk);
        `CHK(o1, 1'b1)
        ctrl_stop <= 1;
        repeat (2) @(posedge pclk);
        `CHK(o1, 1'b0)
        busy = 0;
      end
      apb(0, 12'h020, 0);
      `CHK(rd[1:0], {bad, !busy})
      ctrl_stop <= 0;
      apb(1, 12'h01C, 32'h0000_0003);
      apb(0, 12'h020, 0);
      `CHK({o1, rd[1:0]}, {1'b0, bad | busy, 1'b1})
    end
    conclude();
  end
endmodule // testbench
bind pulse_and_step_output pso_chk chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .match_hit, .pslverr,
  .ctrl_stop, .fast_output_one);
